// ==== cmpr_analog_model.sv ====
module cmpr_analog_model (
    input  wire logic       lvl_a,
    input  wire logic       lvl_b,
    input  wire logic       cmp_a_on,
    input  wire logic       cmp_b_on,
    input  wire logic [2:0] cmp_b_minus_select,
    input  wire logic       internal_reference_on,
    output logic            cmp_a_raw,
    output logic            cmp_b_raw
);
    logic ref_ok;
    // Any comparator b minus code other than the pin gives no decision while the reference is off
    assign ref_ok    = internal_reference_on || cmp_b_minus_select == cmpr_pkg::MINUS_PIN;
    assign cmp_a_raw = cmp_a_on & lvl_a;
    assign cmp_b_raw = cmp_b_on & lvl_b & ref_ok;
endmodule : cmpr_analog_model

// ==== cmpr_pkg.sv ====
package cmpr_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CMP_A_CSR_OFFSET = 8'h18;
    localparam logic [7:0] CMP_B_CSR_OFFSET = 8'h1c;
    localparam int         ADDR_W           = 8;

    localparam logic [31:0] CSR_RESET       = 32'h0000_0000;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ON_BIT        = 0;
    localparam int SPEED_BIT     = 3;
    localparam int A_MINUS_LO    = 4;
    localparam int A_MINUS_W     = 2;
    localparam int B_MINUS_LO    = 4;
    localparam int B_MINUS_W     = 3;
    localparam int WINDOW_BIT    = 8;
    localparam int B_PLUS_LO     = 8;
    localparam int B_PLUS_W      = 3;
    localparam int ROUTE_LO      = 11;
    localparam int ROUTE_W       = 4;
    localparam int INVERT_BIT    = 15;
    localparam int OUT_STATE_BIT = 30;
    localparam int FREEZE_BIT    = 31;

    // Writable masks: reserved bits read zero
    localparam logic [31:0] CMP_A_WR_MASK   = 32'h0000_f931;
    localparam logic [31:0] CMP_B_WR_MASK   = 32'h0000_ff79;

    // ------------------------------------------------------------
    // Route codes and destinations
    // ------------------------------------------------------------
    localparam logic [3:0] ROUTE_NONE       = 4'h0;
    localparam logic [3:0] ROUTE_T4_CAP1    = 4'hb;
    localparam int         NUM_DEST         = 12;

    // Minus-input codes for comparator b
    localparam logic [2:0] MINUS_REF        = 3'h0;
    localparam logic [2:0] MINUS_PIN        = 3'h1;
    localparam logic [2:0] MINUS_QUARTER    = 3'h4;
    localparam logic [2:0] MINUS_HALF       = 3'h5;
    localparam logic [2:0] MINUS_THREEQ     = 3'h6;

    localparam int SYNC_STAGES = 2;

endpackage : cmpr_pkg

// ==== cmpr_regs.sv ====
// Contract
// - Route comparator a output per select bits 14:11; code zero routes nowhere. Comparator a code 1011 also routes nowhere.
// - Bit 15 set inverts comparator a output; clear passes it.
// - Bit 30 of comparator a register reads polarity-adjusted output, read-only.
// - Comparator a freeze bit 31 set makes its whole register ignore writes.
// - Freeze bits clear only on system reset, never by software.
// - Comparator b freeze bit 31 set freezes all its fields until reset.
// - Bit 0 of comparator b register enables it; writable only unfrozen.
// - Bit 3 of comparator b selects speed, zero slow; writable unfrozen.
// - Bits 6:4 select comparator b minus input; listed codes, others reserved.
// - Bits 10:8 select comparator b plus source; writable only unfrozen.
// - Comparator b routing uses same table, code 1011 feeds timer 4 capture 1.
// - Bit 15 of comparator b inverts its output; writable only unfrozen.
// - Bit 30 of comparator b reads its polarity-adjusted output, read-only.
// - Comparator b register at 0x1c resets to all zeros.
// - Bit 0 of comparator a register enables it; writable only unfrozen.
// - No clock enable; reset only by system reset; synchronous to pclk.
module cmpr_regs (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cmp_a_raw,
    input  wire logic        cmp_b_raw,
    output logic             cmp_a_on,
    output logic [1:0]       cmp_a_minus_select,
    output logic             cmp_a_window_mode,
    output logic             cmp_b_on,
    output logic             cmp_b_fast,
    output logic [2:0]       cmp_b_minus_select,
    output logic [2:0]       cmp_b_plus_select,
    output logic [11:0]      timer_dest
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [31:0] cmp_a_csr_ff;
    logic [31:0] cmp_b_csr_ff;
    logic [31:0] prdata_ff;
    logic        pslverr_ff;
    logic        pready_ff;
    logic [11:0] timer_dest_ff;

    logic [1:0]  cmp_sync;
    logic        cmp_a_output_state;
    logic        cmp_b_output_state;
    logic        cmp_a_freeze;
    logic        cmp_b_freeze;
    logic [3:0]  cmp_a_route_select;
    logic [3:0]  cmp_b_route_select;
    logic        cmp_a_invert;
    logic        cmp_b_invert;

    logic        setup;
    logic        wr_a;
    logic        wr_b;
    logic        addr_hit;
    logic [31:0] strb_mask;
    logic [31:0] nxt_prdata;
    logic [11:0] nxt_timer_dest;

    // ------------------------------------------------------------
    // Comparator outputs
    // ------------------------------------------------------------
    cmpr_sync #(
        .WIDTH    (2)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({cmp_b_raw, cmp_a_raw}),
        .sync_out (cmp_sync)
    );

    assign cmp_a_invert       = cmp_a_csr_ff[cmpr_pkg::INVERT_BIT];
    assign cmp_b_invert       = cmp_b_csr_ff[cmpr_pkg::INVERT_BIT];
    assign cmp_a_output_state = cmp_sync[0] ^ cmp_a_invert;
    assign cmp_b_output_state = cmp_sync[1] ^ cmp_b_invert;
    assign cmp_a_freeze       = cmp_a_csr_ff[cmpr_pkg::FREEZE_BIT];
    assign cmp_b_freeze       = cmp_b_csr_ff[cmpr_pkg::FREEZE_BIT];
    assign cmp_a_route_select = cmp_a_csr_ff[cmpr_pkg::ROUTE_LO +: cmpr_pkg::ROUTE_W];
    assign cmp_b_route_select = cmp_b_csr_ff[cmpr_pkg::ROUTE_LO +: cmpr_pkg::ROUTE_W];

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // Zero-wait slave: pready rises in the first access cycle
    assign setup    = psel && !penable;
    assign addr_hit = (paddr == cmpr_pkg::CMP_A_CSR_OFFSET) || (paddr == cmpr_pkg::CMP_B_CSR_OFFSET);
    assign wr_a     = psel && penable && pwrite && (paddr == cmpr_pkg::CMP_A_CSR_OFFSET);
    assign wr_b     = psel && penable && pwrite && (paddr == cmpr_pkg::CMP_B_CSR_OFFSET);

    always_comb begin
        strb_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= setup;
        end
    end

    // ------------------------------------------------------------
    // Comparator a register
    // ------------------------------------------------------------
    // Write only when unfrozen; freeze bit itself can only be set, so
    // software has no way back once locked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_a_csr_ff <= cmpr_pkg::CSR_RESET;
        end else if (wr_a && pready_ff && !cmp_a_freeze) begin
            cmp_a_csr_ff <= (cmp_a_csr_ff & ~(strb_mask & cmpr_pkg::CMP_A_WR_MASK))
                          | (pwdata & strb_mask & cmpr_pkg::CMP_A_WR_MASK);
            if (pstrb[3] && pwdata[cmpr_pkg::FREEZE_BIT]) begin
                cmp_a_csr_ff[cmpr_pkg::FREEZE_BIT] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Comparator b register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_b_csr_ff <= cmpr_pkg::CSR_RESET;
        end else if (wr_b && pready_ff && !cmp_b_freeze) begin
            // Reserved minus codes are stored as written; the analog side
            // gates them on the internal reference like the reference codes
            cmp_b_csr_ff <= (cmp_b_csr_ff & ~(strb_mask & cmpr_pkg::CMP_B_WR_MASK))
                          | (pwdata & strb_mask & cmpr_pkg::CMP_B_WR_MASK);
            if (pstrb[3] && pwdata[cmpr_pkg::FREEZE_BIT]) begin
                cmp_b_csr_ff[cmpr_pkg::FREEZE_BIT] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        nxt_prdata = '0;
        if (paddr == cmpr_pkg::CMP_A_CSR_OFFSET) begin
            nxt_prdata = cmp_a_csr_ff;
            nxt_prdata[cmpr_pkg::OUT_STATE_BIT] = cmp_a_output_state;
        end else if (paddr == cmpr_pkg::CMP_B_CSR_OFFSET) begin
            nxt_prdata = cmp_b_csr_ff;
            nxt_prdata[cmpr_pkg::OUT_STATE_BIT] = cmp_b_output_state;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= '0;
            pslverr_ff <= 1'b0;
        end else if (setup) begin
            prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_prdata;
            pslverr_ff <= !addr_hit;
        end else begin
            prdata_ff  <= '0;
            pslverr_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Timer routing
    // ------------------------------------------------------------
    // One-hot destinations, index = route code - 1. Both comparators may
    // hit the same destination; they are ORed.
    always_comb begin
        nxt_timer_dest = '0;
        for (int i = 1; i <= cmpr_pkg::NUM_DEST; i++) begin
            if (cmp_a_route_select == 4'(i) && cmp_a_route_select != cmpr_pkg::ROUTE_T4_CAP1) begin
                nxt_timer_dest[i-1] = nxt_timer_dest[i-1] | cmp_a_output_state;
            end
            if (cmp_b_route_select == 4'(i)) begin
                nxt_timer_dest[i-1] = nxt_timer_dest[i-1] | cmp_b_output_state;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_dest_ff <= '0;
        end else begin
            timer_dest_ff <= nxt_timer_dest;
        end
    end

    // ------------------------------------------------------------
    // Analog controls
    // ------------------------------------------------------------
    logic        cmp_a_on_ff;
    logic [1:0]  cmp_a_minus_ff;
    logic        cmp_a_window_ff;
    logic        cmp_b_on_ff;
    logic        cmp_b_fast_ff;
    logic [2:0]  cmp_b_minus_ff;
    logic [2:0]  cmp_b_plus_ff;

    // One cycle behind the register so that every output is a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_a_on_ff     <= 1'b0;
            cmp_a_minus_ff  <= '0;
            cmp_a_window_ff <= 1'b0;
            cmp_b_on_ff     <= 1'b0;
            cmp_b_fast_ff   <= 1'b0;
            cmp_b_minus_ff  <= '0;
            cmp_b_plus_ff   <= '0;
        end else begin
            cmp_a_on_ff     <= cmp_a_csr_ff[cmpr_pkg::ON_BIT];
            cmp_a_minus_ff  <= cmp_a_csr_ff[cmpr_pkg::A_MINUS_LO +: cmpr_pkg::A_MINUS_W];
            cmp_a_window_ff <= cmp_a_csr_ff[cmpr_pkg::WINDOW_BIT];
            cmp_b_on_ff     <= cmp_b_csr_ff[cmpr_pkg::ON_BIT];
            cmp_b_fast_ff   <= cmp_b_csr_ff[cmpr_pkg::SPEED_BIT];
            cmp_b_minus_ff  <= cmp_b_csr_ff[cmpr_pkg::B_MINUS_LO +: cmpr_pkg::B_MINUS_W];
            cmp_b_plus_ff   <= cmp_b_csr_ff[cmpr_pkg::B_PLUS_LO +: cmpr_pkg::B_PLUS_W];
        end
    end

    assign cmp_a_on           = cmp_a_on_ff;
    assign cmp_a_minus_select = cmp_a_minus_ff;
    assign cmp_a_window_mode  = cmp_a_window_ff;
    assign cmp_b_on           = cmp_b_on_ff;
    assign cmp_b_fast         = cmp_b_fast_ff;
    assign cmp_b_minus_select = cmp_b_minus_ff;
    assign cmp_b_plus_select  = cmp_b_plus_ff;
    assign timer_dest         = timer_dest_ff;
    assign prdata             = prdata_ff;
    assign pready             = pready_ff;
    assign pslverr            = pslverr_ff;

endmodule : cmpr_regs

// ==== cmpr_regs_properties.sv ====
module cmpr_regs_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        cmp_a_on,
    input wire logic [1:0]  cmp_a_minus_select,
    input wire logic        cmp_a_window_mode,
    input wire logic        cmp_b_on,
    input wire logic        cmp_b_fast,
    input wire logic [2:0]  cmp_b_minus_select,
    input wire logic [2:0]  cmp_b_plus_select
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_ok;
    logic is_a;
    logic is_b;
    logic a_frz_ff;
    logic b_frz_ff;
    assign wr_ok = psel && penable && pready && pwrite;
    assign is_a  = paddr == cmpr_pkg::CMP_A_CSR_OFFSET;
    assign is_b  = paddr == cmpr_pkg::CMP_B_CSR_OFFSET;
    // Shadow of the freeze bits, so frozen periods are known without reading back
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            a_frz_ff <= 1'b0;
            b_frz_ff <= 1'b0;
        end else begin
            a_frz_ff <= a_frz_ff | (wr_ok && is_a && pstrb[3] && pwdata[31]);
            b_frz_ff <= b_frz_ff | (wr_ok && is_b && pstrb[3] && pwdata[31]);
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_write_a;
        wr_ok && is_a && pstrb[0] && !a_frz_ff;
    endsequence
    sequence s_write_b;
        wr_ok && is_b && pstrb[0] && !b_frz_ff;
    endsequence
    a_ready_after_setup: assert property (s_setup |=> pready) else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready) else $error("ready held too long");
    a_err_unmapped: assert property (pready && !is_a && !is_b |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_idle_rdata_zero: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
    // Controls follow the register one cycle later, so the write shows two edges on
    a_a_on_write: assert property (s_write_a |-> ##2 cmp_a_on == $past(pwdata[0], 2))
        else $error("comparator a enable not written");
    a_b_low_write: assert property (s_write_b |-> ##2 {cmp_b_on, cmp_b_fast, cmp_b_minus_select} ==
        {$past(pwdata[0], 2), $past(pwdata[3], 2), $past(pwdata[6:4], 2)}) else $error("comparator b low fields wrong");
    a_b_plus_write: assert property (wr_ok && is_b && pstrb[1] && !b_frz_ff |-> ##2
        cmp_b_plus_select == $past(pwdata[10:8], 2)) else $error("comparator b plus select wrong");
    // The locking write itself may still move the controls one cycle later
    a_a_frozen_hold: assert property (a_frz_ff && $past(a_frz_ff) |=>
        $stable({cmp_a_on, cmp_a_minus_select, cmp_a_window_mode})) else $error("frozen comparator a changed");
    a_b_frozen_hold: assert property (b_frz_ff && $past(b_frz_ff) |=>
        $stable({cmp_b_on, cmp_b_fast, cmp_b_minus_select, cmp_b_plus_select})) else $error("frozen comparator b changed");
endmodule : cmpr_regs_checker

bind cmpr_regs cmpr_regs_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .cmp_a_on, .cmp_a_minus_select, .cmp_a_window_mode, .cmp_b_on, .cmp_b_fast,
    .cmp_b_minus_select, .cmp_b_plus_select);

// ==== cmpr_sync.sv ====
module cmpr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------
    // Two-stage synchroniser; first stage feeds only the second
    // ------------------------------------------------------------
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule : cmpr_sync

// ==== tb.sv ====
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] A_ADR = cmpr_pkg::CMP_A_CSR_OFFSET;
    localparam logic [7:0] B_ADR = cmpr_pkg::CMP_B_CSR_OFFSET;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic        cmp_a_raw, cmp_b_raw, lvl_a, lvl_b, ref_on;
    logic        cmp_a_on, cmp_a_window_mode, cmp_b_on, cmp_b_fast;
    logic [1:0]  cmp_a_minus_select;
    logic [2:0]  cmp_b_minus_select, cmp_b_plus_select;
    logic [11:0] timer_dest, exp;
    int          fails = 0, samples_checked = 0, cyc = 0;
    always #50 pclk = ~pclk;
    cmpr_regs i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .cmp_a_raw, .cmp_b_raw, .cmp_a_on, .cmp_a_minus_select, .cmp_a_window_mode, .cmp_b_on, .cmp_b_fast,
        .cmp_b_minus_select, .cmp_b_plus_select, .timer_dest);
    cmpr_analog_model i_model (.lvl_a, .lvl_b, .cmp_a_on, .cmp_b_on, .cmp_b_minus_select,
        .internal_reference_on(ref_on), .cmp_a_raw, .cmp_b_raw);
    task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
        samples_checked++;
        if (seen !== expv) begin
            fails++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask : chk
    // One APB transfer; an idle cycle follows so the next setup never collides with the release
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pstrb = 4'hf;
        lvl_a = 0; lvl_b = 0; ref_on = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        ref_on <= 1'b1;
        apb(0, A_ADR, 0); chk(rd, cmpr_pkg::CSR_RESET);
        apb(0, B_ADR, 0); chk(rd, cmpr_pkg::CSR_RESET);
        $display("test reset values done");
        apb(1, B_ADR, 32'h3fff_7fff); apb(0, B_ADR, 0); chk(rd, 32'h0000_7f79);
        chk({cmp_b_on, cmp_b_fast, cmp_b_minus_select, cmp_b_plus_select}, 8'hff);
        apb(1, A_ADR, 32'h3fff_7fff); apb(0, A_ADR, 0); chk(rd, 32'h0000_7931);
        chk({cmp_a_on, cmp_a_minus_select, cmp_a_window_mode}, 4'hf);
        for (int k = 0; k < 7; k++) begin
            apb(1, B_ADR, 32'(k) << 4); apb(0, B_ADR, 0); chk(rd, 32'(k) << 4);
        end
        $display("test field storage done");
        apb(1, A_ADR, 0); lvl_a <= 1'b1; lvl_b <= 1'b1;
        for (int c = 0; c < 2; c++) begin
            for (int k = 1; k < 16; k++) begin
                apb(1, c ? B_ADR : A_ADR, (32'(k) << 11) | 32'h1);
                repeat (4) @(posedge pclk);
                exp = (k <= 12 && !(c == 0 && k == 11)) ? 12'h1 << (k - 1) : 12'h0;
                chk(timer_dest, exp);
                apb(0, c ? B_ADR : A_ADR, 0); chk(rd[30], 1'b1);
            end
            apb(1, c ? B_ADR : A_ADR, 0);
        end
        $display("test routing done");
        apb(1, A_ADR, 32'h0000_8801); repeat (4) @(posedge pclk); chk(timer_dest, 12'h0);
        apb(0, A_ADR, 0); chk(rd[30], 1'b0);
        apb(1, A_ADR, 0); apb(1, B_ADR, 32'h0000_8801); repeat (4) @(posedge pclk); chk(timer_dest, 12'h0);
        lvl_b <= 1'b0; @(posedge pclk); chk(timer_dest, 12'h0);
        repeat (3) @(posedge pclk); chk(timer_dest, 12'h1);
        apb(0, B_ADR, 0); chk(rd[30], 1'b1);
        apb(0, 8'h20, 0); chk(er, 1'b1); chk(rd, 32'h0);
        $display("test polarity and refusal done");
        lvl_a <= 1'b0;
        apb(1, A_ADR, 32'h8000_0011); apb(1, A_ADR, 32'h0); apb(0, A_ADR, 0); chk(rd, 32'h8000_0011);
        apb(1, B_ADR, 32'h8000_0109); apb(1, B_ADR, 32'h0000_ffff); apb(0, B_ADR, 0); chk(rd, 32'h8000_0109);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, A_ADR, 0); chk(rd, 32'h0);
        apb(0, B_ADR, 0); chk(rd, 32'h0);
        $display("test freeze done");
        give_verdict();
    end
endmodule : tb
